// *** include/qsr_pkg.sv ***
// Constants and carrier types for the quad recirculating static shift register.
// Assumes one 40 MHz system clock; every device pin is asynchronous to it.
// Operation
// (R01) Four separate serial registers, each with own input, output, recirculate.
// (R02) Register length is 80 or 96 bits, chosen at build time.
// (R03) One shared shift clock drives all four registers together.
// (R04) Registers advance only on the shift clock's high-to-low transition.
// (R05) Recirculate low at the shifting edge: the data input enters stage one.
// (R06) Recirculate high at the shifting edge: the output bit re-enters stage one.
// (R07) Master is dynamic while clock high; data holds forever with clock low.
// (R08) Each stage is master-slave: master captures high, slave takes it low.
// (R09) Controller keeps the clock high at most 100 us, 10 us military.
// (R10) Controller keeps shift clock between standstill and 3 MHz.
// (R11) Controller holds data and recirculate stable around the falling edge.
// (R12) Output shows the bit entered register-length falling edges earlier.
package qsr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned LANES = 4;
  localparam int unsigned LEN_SHORT = 80;
  localparam int unsigned LEN_LONG = 96;
  localparam int unsigned BUF_DEPTH = 2;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] CNT_ONE = 2'h1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef logic [LANES-1:0] qsr_word_type;

  typedef struct packed {
    qsr_word_type din;
    qsr_word_type recirc_select;
  } qsr_pins_type;

  typedef struct packed {
    logic sclk;
    qsr_pins_type pins;
  } qsr_sample_type;

  localparam qsr_sample_type SAMPLE_RST = '0;
  localparam qsr_word_type WORD_RST = '0;

endpackage

// *** rtl/qsr_quad_shift.sv ***
// Quad static shift register with per-register recirculation.
// Assumes the shift clock, data and recirculate pins come from outside the
// clk_i domain and that the shift clock stays well below clk_i / 6.
`timescale 1ns/1ps
module qsr_quad_shift #(
  parameter int unsigned LEN = qsr_pkg::LEN_SHORT
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic shift_clk_i,
  input wire qsr_pkg::qsr_pins_type pins_i,
  output qsr_pkg::qsr_word_type data_o,
  output qsr_pkg::qsr_word_type word_o,
  output logic word_valid_o,
  input wire logic word_ready_i
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  qsr_pkg::qsr_sample_type meta_r;
  qsr_pkg::qsr_sample_type sync_r;
  logic sclk_d_r;
  logic fall;
  logic rise;

  // (R10) pins sampled twice; slow clock leaves several cycles per phase
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= qsr_pkg::SAMPLE_RST;
      sync_r <= qsr_pkg::SAMPLE_RST;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      meta_r <= {shift_clk_i, pins_i};
      sync_r <= meta_r;
      sclk_d_r <= sync_r.sclk;
    end
  end

  // (R03) one shared clock edge detector
  assign fall = sclk_d_r & ~sync_r.sclk;
  assign rise = ~sclk_d_r & sync_r.sclk;

  // ****************************************
  // Shift request and stall
  // ****************************************
  logic pend_r;
  logic [1:0] cnt_r;
  logic buf_full;
  logic shift_go;

  assign buf_full = (cnt_r == qsr_pkg::BUF_FULL);
  // A full buffer holds the shift back instead of dropping a word
  assign shift_go = pend_r & ~buf_full;

  // (R04) falling edge arms one shift; a new edge wins over the clear
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pend_r <= 1'b0;
    else if (fall)
      pend_r <= 1'b1;
    else if (shift_go)
      pend_r <= 1'b0;
  end

  // ****************************************
  // Master stages
  // ****************************************
  qsr_pkg::qsr_word_type master_r;
  qsr_pkg::qsr_word_type master_nxt;

  // (R05) recirculate low: data input feeds the master
  // (R06) recirculate high: output bit feeds the master
  assign master_nxt = (sync_r.pins.din & ~sync_r.pins.recirc_select) |
                      (data_o & sync_r.pins.recirc_select);

  // (R08) master follows input only while the clock is high
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      master_r <= qsr_pkg::WORD_RST;
    else if (sync_r.sclk)
      master_r <= master_nxt;
  end

  // ****************************************
  // Slave chains
  // ****************************************
  logic [LEN-1:0] sr_r [qsr_pkg::LANES];
  qsr_pkg::qsr_word_type next_out;
  qsr_pkg::qsr_word_type first_stage;

  // (R01) four independent chains
  // (R07) chains only move on a shift, so a stopped clock holds data
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < qsr_pkg::LANES; i++)
        sr_r[i] <= '0;
    end
    else if (shift_go)
    begin
      for (int i = 0; i < qsr_pkg::LANES; i++)
        sr_r[i] <= {sr_r[i][LEN-2:0], master_r[i]};
    end
  end

  // (R02) tap positions follow the build-time length
  // (R12) output is the last slave stage
  always_comb
  begin
    for (int i = 0; i < qsr_pkg::LANES; i++)
    begin
      data_o[i] = sr_r[i][LEN-1];
      next_out[i] = sr_r[i][LEN-2];
      first_stage[i] = sr_r[i][0];
    end
  end

  // ****************************************
  // Two-entry output buffer
  // ****************************************
  qsr_pkg::qsr_word_type mem_r [qsr_pkg::BUF_DEPTH];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic pop;

  assign word_valid_o = (cnt_r != 2'h0);
  assign pop = word_valid_o & word_ready_i;
  assign word_o = mem_r[rd_ptr_r];

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mem_r[0] <= qsr_pkg::WORD_RST;
      mem_r[1] <= qsr_pkg::WORD_RST;
      wr_ptr_r <= 1'b0;
    end
    else if (shift_go)
    begin
      mem_r[wr_ptr_r] <= next_out;
      wr_ptr_r <= ~wr_ptr_r;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rd_ptr_r <= 1'b0;
    else if (pop)
      rd_ptr_r <= ~rd_ptr_r;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cnt_r <= 2'h0;
    else if (shift_go && !pop)
      cnt_r <= cnt_r + qsr_pkg::CNT_ONE;
    else if (pop && !shift_go)
      cnt_r <= cnt_r - qsr_pkg::CNT_ONE;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_fall;
    fall ##1 pend_r;
  endsequence

  sequence s_shift;
    shift_go ##1 1'b1;
  endsequence

  AST_FALL_ARMS: assert property (fall |=> pend_r) // (R04)
    else $error("falling edge did not arm a shift");

  AST_FALL_SHIFTS: assert property (s_fall |-> ##[0:300] shift_go) // (R04)
    else $error("armed shift never performed");

  AST_RISE_NO_SHIFT: assert property (rise && !pend_r |=> !shift_go) // (R04)
    else $error("rising edge caused a shift");

  AST_HOLD_LOW: assert property (!shift_go |=> $stable(data_o)) // (R07)
    else $error("output moved without a shift");

  AST_MASTER_LOW: assert property (!sync_r.sclk |=> $stable(master_r)) // (R08)
    else $error("master changed while clock low");

  AST_SLAVE_TAKES: assert property (s_shift |-> // (R03)
      first_stage == $past(master_r))
    else $error("slave did not take master");

  AST_TAP: assert property (shift_go |=> data_o == $past(next_out)) // (R12)
    else $error("output tap wrong after shift");

  AST_BUF_BOUND: assert property (cnt_r <= qsr_pkg::BUF_FULL) // (R01)
    else $error("buffer overfilled");

  AST_BUF_STALL: assert property (buf_full |-> !shift_go) // (R07)
    else $error("shift while buffer full");

  for (genvar g = 0; g < qsr_pkg::LANES; g++)
  begin : g_lane
    AST_LOAD_DIN: assert property (sync_r.sclk && // (R05)
        !sync_r.pins.recirc_select[g] |=>
        master_r[g] == $past(sync_r.pins.din[g]))
      else $error("master missed data input");

    AST_RECIRC: assert property (sync_r.sclk && // (R06)
        sync_r.pins.recirc_select[g] |=> master_r[g] == $past(data_o[g]))
      else $error("master missed recirculated bit");

    AST_CHAIN: assert property (shift_go |=> // (R02)
        sr_r[g][0] == $past(master_r[g]))
      else $error("first stage did not take master");
  end

endmodule // qsr_quad_shift

// *** testbench/qsr_ctrl_model.sv ***
// Far-side controller model: drives shift clock, data and recirculate.
// Assumes the bench calls rise, then fall, once per shift.
`timescale 1ns/1ps
module qsr_ctrl_model (
  input wire logic clk_i,
  output logic shift_clk_o,
  output qsr_pkg::qsr_pins_type pins_o
);
  initial
  begin
    shift_clk_o = 1'b0;
    pins_o = '0;
  end
  task automatic rise(input logic [3:0] d, input logic [3:0] r);
    pins_o.din = d;
    pins_o.recirc_select = r;
    shift_clk_o = 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  // Short high, pins held past fall
  task automatic fall();
    shift_clk_o = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    // Stale data inputs flip so old data is never mistaken for held data
    pins_o.din = ~pins_o.din;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
endmodule // qsr_ctrl_model

// *** testbench/quad_static_recirc_shift_register_tb_top.sv ***
// Bench: random shifts against a per-lane bit-array model.
// Assumes qsr_ctrl_model plays the controller.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("ERROR %s exp %h got %h", n, e, g); \
    end \
  end
module quad_static_recirc_shift_register_tb_top;
  localparam int unsigned LEN = qsr_pkg::LEN_LONG;
  localparam int unsigned LEN_S = qsr_pkg::LEN_SHORT;
  logic [LEN_S-1:0] srs [4];
  qsr_pkg::qsr_word_type data_s, ex_s;
  logic clk_i, nrst_i, shift_clk, ready, stall, word_valid_o;
  qsr_pkg::qsr_pins_type pins;
  qsr_pkg::qsr_word_type data_o, word_o, ex_out, prev, ex;
  logic [LEN-1:0] sr [4];
  qsr_pkg::qsr_word_type q [$];
  int errors, compares, n;
  logic [31:0] seed = 32'h0000_d919;

  qsr_quad_shift #(.LEN(LEN)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .shift_clk_i(shift_clk), .pins_i(pins), .data_o(data_o),
    .word_o(word_o), .word_valid_o(word_valid_o), .word_ready_i(ready));
  // Short variant on the same pins and consumer
  qsr_quad_shift #(.LEN(LEN_S)) dut_s (.clk_i(clk_i), .nrst_i(nrst_i),
    .shift_clk_i(shift_clk), .pins_i(pins), .data_o(data_s),
    .word_o(), .word_valid_o(), .word_ready_i(ready));
  qsr_ctrl_model ctl (.clk_i(clk_i), .shift_clk_o(shift_clk), .pins_o(pins));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    if (word_valid_o === 1'b1 && ready === 1'b1)
    begin
      ex = q.pop_front();
      `CHK("word_o", ex, word_o)
    end
    #1;
    ready <= !stall && ((rnd() & 32'h0000_0003) != 32'h0000_0000);
  end

  task automatic step(input bit chk);
    logic [31:0] v;
    v = rnd();
    ctl.rise(v[3:0], v[7:4]);
    `CHK("data_o at rise", ex_out, data_o)
    `CHK("short data_o at rise", ex_s, data_s)
    prev = ex_out;
    for (int l = 0; l < 4; l++)
    begin
      sr[l] = {sr[l][LEN-2:0], v[4+l] ? sr[l][LEN-1] : v[l]};
      ex_out[l] = sr[l][LEN-1];
      srs[l] = {srs[l][LEN_S-2:0], v[4+l] ? srs[l][LEN_S-1] : v[l]};
      ex_s[l] = srs[l][LEN_S-1];
    end
    q.push_back(ex_out);
    ctl.fall();
    if (chk)
    begin
      `CHK("data_o", ex_out, data_o)
      `CHK("short data_o", ex_s, data_s)
    end
  endtask

  task automatic close_out();
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    nrst_i = 1'b0;
    ready = 1'b0;
    stall = 1'b0;
    errors = 0;
    compares = 0;
    ex_out = '0;
    ex_s = '0;
    for (int l = 0; l < 4; l++)
    begin
      sr[l] = '0;
      srs[l] = '0;
    end
    repeat (2) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    repeat (3 * LEN) step(1'b1);
    // Drain first: a leftover word would merge two stalled shifts
    n = 0;
    while (word_valid_o !== 1'b0 && n < 50)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK("word_valid_o idle", 1'b0, word_valid_o)
    // Third shift must wait on a full two-word buffer
    stall = 1'b1;
    repeat (3) step(1'b0);
    `CHK("data_o stalled", prev, data_o)
    `CHK("word_valid_o stalled", 1'b1, word_valid_o)
    stall = 1'b0;
    n = 0;
    while (q.size() != 0 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    #1;
    `CHK("words left", 0, q.size())
    `CHK("data_o resumed", ex_out, data_o)
    `CHK("short data_o resumed", ex_s, data_s)
    repeat (300) @(posedge clk_i);
    #1;
    `CHK("data_o parked", ex_out, data_o)
    `CHK("word_valid_o drained", 1'b0, word_valid_o)
    close_out();
  end
endmodule // quad_static_recirc_shift_register_tb_top
